// ===== hw/ieq_map.vh
// Constants of the internal event qualifier: register map, digit fields, codes and timing
`ifndef IEQ_MAP_VH
`define IEQ_MAP_VH

// ------------------------------------------------------------
// Register map (word addresses on the plain register port)
// ------------------------------------------------------------
`define IEQ_NUM_EV        5
`define IEQ_OFS_CFG2      4'h0
`define IEQ_OFS_CFG3      4'h1
`define IEQ_OFS_MAIN      4'h2
`define IEQ_OFS_ON_DLY    4'h3
`define IEQ_OFS_OFF_DLY   4'h4
`define IEQ_OFS_EV_STAT   4'h5
`define IEQ_OFS_INT_STAT  8'h60
`define IEQ_OFS_INT_MASK  8'h61
`define IEQ_OFS_GLB_STAT  8'h62

// ------------------------------------------------------------
// Digit fields, one nibble per decimal digit from the right
// ------------------------------------------------------------
`define IEQ_DIG_POL       3:0
`define IEQ_DIG_STBY      7:4
`define IEQ_DIG_RDY       11:8
`define IEQ_DIG_ALM       3:0
`define IEQ_DIG_SPOFF     7:4
`define IEQ_DIG_UNIT      11:8

// ------------------------------------------------------------
// Digit codes
// ------------------------------------------------------------
`define IEQ_POL_REVERSE   4'h1
`define IEQ_STBY_ON       4'h1
`define IEQ_STBY_SPCHG    4'h2
`define IEQ_RDY_FORCE_OFF 4'h1
`define IEQ_ALM_NONE      4'h0
`define IEQ_ALM_DIR_OR    4'h1
`define IEQ_ALM_DIR_AND   4'h2
`define IEQ_ALM_REV_OR    4'h3
`define IEQ_ALM_REV_AND   4'h4
`define IEQ_SPOFF_ON      4'h1
`define IEQ_UNIT_100MS    4'h0
`define IEQ_UNIT_1S       4'h1
`define IEQ_UNIT_1MIN     4'h2

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define IEQ_CFG_RST       12'h000
`define IEQ_MAIN_RST      16'h0000
`define IEQ_DLY_RST       14'h0000

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define IEQ_CLK_NS        4
`define IEQ_TICK_NS       100000000
`define IEQ_SUB_LAST_1S   10'h009
`define IEQ_SUB_LAST_1MIN 10'h257
`define IEQ_DLY_MAX       14'h270f

`endif

// ===== hw/ieq_delay.v
// ON and OFF delay timer of one internal event
`timescale 1ns/1ps
`include "ieq_map.vh"

module ieq_delay (
	// Clock and reset
	input  wire        sys_clk,
	input  wire        rst_b,
	// Time base
	input  wire        tick,
	input  wire [3:0]  unit_sel,
	// Event level and delays
	input  wire        in_lvl,
	input  wire [13:0] on_dly,
	input  wire [13:0] off_dly,
	output reg         out_reg
);

	reg  [9:0]  sub_reg;
	reg  [13:0] cnt_reg;
	wire [9:0]  sub_last;
	wire [13:0] target;

	// Unknown unit codes fall back to the 0.1 s base
	assign sub_last = (unit_sel == `IEQ_UNIT_1S)   ? `IEQ_SUB_LAST_1S :
	                  (unit_sel == `IEQ_UNIT_1MIN) ? `IEQ_SUB_LAST_1MIN : 10'h000; // [RULE12]
	assign target   = in_lvl ? on_dly : off_dly;

	// ------------------------------------------------------------
	// Delay counting
	// ------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (!rst_b) begin
			out_reg <= 1'b0;
			sub_reg <= 10'h000;
			cnt_reg <= 14'h0000;
		end else if (in_lvl == out_reg) begin
			sub_reg <= 10'h000;
			cnt_reg <= 14'h0000;
		end else if (cnt_reg >= target) begin
			out_reg <= in_lvl; // [RULE13]
			sub_reg <= 10'h000;
			cnt_reg <= 14'h0000;
		end else if (tick) begin
			if (sub_reg >= sub_last) begin
				sub_reg <= 10'h000;
				cnt_reg <= cnt_reg + 14'h0001; // [RULE13]
			end else begin
				sub_reg <= sub_reg + 10'h001;
			end
		end
	end

endmodule

// ===== hw/ieq_top.v
// Five internal event qualifiers with register port and interrupt
`timescale 1ns/1ps
`include "ieq_map.vh"

// Notes on behaviour
// [RULE1] Polarity digit: 0 direct, 1 inverted
// [RULE2] Standby digit: none, standby, plus SP re-arm
// [RULE3] READY digit 1 forces event OFF
// [RULE4] Standby holds OFF until raw condition drops
// [RULE5] After standby clears, next ON condition passes
// [RULE6] Standby enabled: OFF in READY, re-arm leaving
// [RULE7] Re-arm only on real setpoint value change
// [RULE8] Alarm digit: none, dir OR/AND, rev OR/AND
// [RULE9] None passes; direct ORs or ANDs alarm-present
// [RULE10] Reverse ORs or ANDs inverted alarm-present
// [RULE11] Special OFF: held OFF when main is zero
// [RULE12] Delay unit digit: 0.1 s, 1 s, 1 min
// [RULE13] ON and OFF delays, up to 9999 units
// [RULE14] Five independent instances, shared alarm and mode
// [RULE15] Fourth digit ignored; stage order fixed
module ieq_top #(
	parameter TICK_CYC = `IEQ_TICK_NS / `IEQ_CLK_NS
) (
	// Clock and reset
	input  wire        sys_clk,
	input  wire        rst_b,
	// Register port
	input  wire [7:0]  reg_addr,
	input  wire [15:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [15:0] reg_rdata,
	// Event sources
	input  wire [4:0]  event_raw,
	input  wire        alarm_present,
	input  wire        ready_mode,
	input  wire [15:0] sp_value,
	// Event results
	output wire [4:0]  event_out,
	output reg         irq
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function [13:0] dly_clamp;
		input [15:0] val;
		begin
			if (val > {2'b00, `IEQ_DLY_MAX})
				dly_clamp = `IEQ_DLY_MAX;
			else
				dly_clamp = val[13:0];
		end
	endfunction

	function ev_hit;
		input [7:0] addr;
		input [3:0] ofs;
		input [2:0] idx;
		begin
			ev_hit = (addr[7] == 1'b0) && (addr[6:4] == idx) && (addr[3:0] == ofs);
		end
	endfunction

	function stby_enabled;
		input [3:0] dig;
		begin
			stby_enabled = (dig == `IEQ_STBY_ON) || (dig == `IEQ_STBY_SPCHG);
		end
	endfunction

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	reg  [11:0] cfg2_reg    [0:4];
	reg  [11:0] cfg3_reg    [0:4];
	reg  [15:0] main_reg    [0:4];
	reg  [13:0] on_dly_reg  [0:4];
	reg  [13:0] off_dly_reg [0:4];
	reg  [4:0]  standby_reg;
	reg  [4:0]  int_stat_reg;
	reg  [4:0]  int_mask_reg;
	reg  [4:0]  out_prev_reg;
	reg         ready_prev_reg;
	reg  [15:0] sp_prev_reg;
	reg  [24:0] tick_cnt_reg;
	reg         tick_reg;
	reg  [15:0] rdata_next;
	wire [4:0]  int_stat_next;
	wire [4:0]  final_lvl;
	wire        run_start;
	wire        sp_change;
	integer     i;

	// ------------------------------------------------------------
	// Shared time base and mode edges
	// ------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (!rst_b) begin
			tick_cnt_reg <= 25'h0000000;
			tick_reg     <= 1'b0;
		end else if (tick_cnt_reg >= TICK_CYC[24:0] - 25'h0000001) begin
			tick_cnt_reg <= 25'h0000000;
			tick_reg     <= 1'b1;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 25'h0000001;
			tick_reg     <= 1'b0;
		end
	end

	always @(posedge sys_clk) begin
		if (!rst_b) begin
			ready_prev_reg <= 1'b0;
			sp_prev_reg    <= 16'h0000;
		end else begin
			ready_prev_reg <= ready_mode;
			sp_prev_reg    <= sp_value;
		end
	end

	assign run_start = ready_prev_reg & ~ready_mode; // [RULE6]
	// Group changes that leave the value alone do not show here
	assign sp_change = (sp_value != sp_prev_reg); // [RULE7]

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (!rst_b) begin
			for (i = 0; i < `IEQ_NUM_EV; i = i + 1) begin
				cfg2_reg[i]    <= `IEQ_CFG_RST; // [RULE1]
				cfg3_reg[i]    <= `IEQ_CFG_RST; // [RULE8]
				main_reg[i]    <= `IEQ_MAIN_RST;
				on_dly_reg[i]  <= `IEQ_DLY_RST;
				off_dly_reg[i] <= `IEQ_DLY_RST;
			end
			int_mask_reg <= 5'h00;
		end else if (reg_wr) begin
			for (i = 0; i < `IEQ_NUM_EV; i = i + 1) begin
				// Fourth digit is not stored
				if (ev_hit(reg_addr, `IEQ_OFS_CFG2, i[2:0]))
					cfg2_reg[i] <= reg_wdata[11:0]; // [RULE15]
				if (ev_hit(reg_addr, `IEQ_OFS_CFG3, i[2:0]))
					cfg3_reg[i] <= reg_wdata[11:0]; // [RULE15]
				if (ev_hit(reg_addr, `IEQ_OFS_MAIN, i[2:0]))
					main_reg[i] <= reg_wdata;
				if (ev_hit(reg_addr, `IEQ_OFS_ON_DLY, i[2:0]))
					on_dly_reg[i] <= dly_clamp(reg_wdata); // [RULE13]
				if (ev_hit(reg_addr, `IEQ_OFS_OFF_DLY, i[2:0]))
					off_dly_reg[i] <= dly_clamp(reg_wdata); // [RULE13]
			end
			if (reg_addr == `IEQ_OFS_INT_MASK)
				int_mask_reg <= reg_wdata[4:0];
		end
	end

	// ------------------------------------------------------------
	// Per-event qualifier stages
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < `IEQ_NUM_EV; gi = gi + 1) begin : g_ev
			wire       pol_lvl;
			wire       stby_en;
			wire       forced_off;
			wire       staged_lvl;
			reg        comb_lvl;
			wire       spoff;

			assign pol_lvl = event_raw[gi] ^
			                 (cfg2_reg[gi][`IEQ_DIG_POL] == `IEQ_POL_REVERSE); // [RULE1]
			assign stby_en = stby_enabled(cfg2_reg[gi][`IEQ_DIG_STBY]); // [RULE2]

			// Standby is judged on the condition before polarity
			always @(posedge sys_clk) begin
				if (!rst_b)
					standby_reg[gi] <= 1'b1; // [RULE4]
				else if (!stby_en)
					standby_reg[gi] <= 1'b0; // [RULE2]
				else if (run_start)
					standby_reg[gi] <= 1'b1; // [RULE6]
				else if (sp_change &&
				         cfg2_reg[gi][`IEQ_DIG_STBY] == `IEQ_STBY_SPCHG)
					standby_reg[gi] <= 1'b1; // [RULE7]
				else if (!event_raw[gi])
					standby_reg[gi] <= 1'b0; // [RULE5]
			end

			assign forced_off = (stby_en && (ready_mode || standby_reg[gi])) || // [RULE6] [RULE4]
			                    (ready_mode &&
			                     cfg2_reg[gi][`IEQ_DIG_RDY] == `IEQ_RDY_FORCE_OFF); // [RULE3]
			assign staged_lvl = pol_lvl & ~forced_off; // [RULE15]

			always @* begin
				case (cfg3_reg[gi][`IEQ_DIG_ALM])
				`IEQ_ALM_DIR_OR:  comb_lvl = staged_lvl | alarm_present; // [RULE9]
				`IEQ_ALM_DIR_AND: comb_lvl = staged_lvl & alarm_present; // [RULE9]
				`IEQ_ALM_REV_OR:  comb_lvl = staged_lvl | ~alarm_present; // [RULE10]
				`IEQ_ALM_REV_AND: comb_lvl = staged_lvl & ~alarm_present; // [RULE10]
				default:          comb_lvl = staged_lvl; // [RULE9]
				endcase
			end

			assign spoff = (cfg3_reg[gi][`IEQ_DIG_SPOFF] == `IEQ_SPOFF_ON) &&
			               (main_reg[gi] == 16'h0000);
			assign final_lvl[gi] = comb_lvl & ~spoff; // [RULE11]

			ieq_delay u_delay (
				.sys_clk  (sys_clk),
				.rst_b    (rst_b),
				.tick     (tick_reg),
				.unit_sel (cfg3_reg[gi][`IEQ_DIG_UNIT]),
				.in_lvl   (final_lvl[gi]),
				.on_dly   (on_dly_reg[gi]),
				.off_dly  (off_dly_reg[gi]),
				.out_reg  (event_out[gi])
			); // [RULE14] [RULE12]
		end
	endgenerate

	// ------------------------------------------------------------
	// Interrupt: rising event outputs set sticky bits
	// ------------------------------------------------------------
	assign int_stat_next = (int_stat_reg &
	                        ~((reg_wr && reg_addr == `IEQ_OFS_INT_STAT) ? reg_wdata[4:0]
	                                                                   : 5'h00)) |
	                       (event_out & ~out_prev_reg);

	always @(posedge sys_clk) begin
		if (!rst_b) begin
			int_stat_reg <= 5'h00;
			out_prev_reg <= 5'h00;
			irq          <= 1'b0;
		end else begin
			int_stat_reg <= int_stat_next;
			out_prev_reg <= event_out;
			irq          <= |(int_stat_next & int_mask_reg);
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	always @* begin
		rdata_next = 16'h0000;
		for (i = 0; i < `IEQ_NUM_EV; i = i + 1) begin
			if (ev_hit(reg_addr, `IEQ_OFS_CFG2, i[2:0]))
				rdata_next = {4'h0, cfg2_reg[i]};
			if (ev_hit(reg_addr, `IEQ_OFS_CFG3, i[2:0]))
				rdata_next = {4'h0, cfg3_reg[i]};
			if (ev_hit(reg_addr, `IEQ_OFS_MAIN, i[2:0]))
				rdata_next = main_reg[i];
			if (ev_hit(reg_addr, `IEQ_OFS_ON_DLY, i[2:0]))
				rdata_next = {2'b00, on_dly_reg[i]};
			if (ev_hit(reg_addr, `IEQ_OFS_OFF_DLY, i[2:0]))
				rdata_next = {2'b00, off_dly_reg[i]};
			if (ev_hit(reg_addr, `IEQ_OFS_EV_STAT, i[2:0]))
				rdata_next = {12'h000, event_raw[i], standby_reg[i],
				              final_lvl[i], event_out[i]};
		end
		if (reg_addr == `IEQ_OFS_INT_STAT)
			rdata_next = {11'h000, int_stat_reg};
		if (reg_addr == `IEQ_OFS_INT_MASK)
			rdata_next = {11'h000, int_mask_reg};
		if (reg_addr == `IEQ_OFS_GLB_STAT)
			rdata_next = {9'h000, event_out, alarm_present, ready_mode};
	end

	always @(posedge sys_clk) begin
		if (!rst_b)
			reg_rdata <= 16'h0000;
		else if (reg_rd)
			reg_rdata <= rdata_next;
		else
			reg_rdata <= 16'h0000;
	end

endmodule

// ===== testbench/ieq_chk_assertions.sv
// Port assertions of the event qualifier top
`timescale 1ns/1ps
module ieq_chk #(
	parameter TICK_CYC = 4
) (
	// Clock and reset
	input wire        sys_clk,
	input wire        rst_b,
	// Register port
	input wire [7:0]  reg_addr,
	input wire [15:0] reg_wdata,
	input wire        reg_wr,
	input wire        reg_rd,
	input wire [15:0] reg_rdata,
	// Events
	input wire [4:0]  event_raw,
	input wire        alarm_present,
	input wire        ready_mode,
	input wire [15:0] sp_value,
	input wire [4:0]  event_out,
	input wire        irq
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// Shadow of the interrupt mask
	reg [4:0] msk_reg;
	always @(posedge sys_clk)
		if (!rst_b)
			msk_reg <= 5'h00;
		else if (reg_wr && reg_addr == 8'h61)
			msk_reg <= reg_wdata[4:0];

	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
		else $error("read data outside slot");
	a_cfg_top: assert property (reg_rd && reg_addr < 8'h50 && reg_addr[3:1] == 3'h0
		|=> reg_rdata[15:12] == 4'h0) else $error("fourth digit stored");
	a_dly_clamp: assert property (reg_rd && reg_addr < 8'h50
		&& (reg_addr[3:0] == 4'h3 || reg_addr[3:0] == 4'h4) |=> reg_rdata <= 16'h270f)
		else $error("delay above limit");
	a_unmapped_zero: assert property (reg_rd && (reg_addr > 8'h62
		|| (reg_addr < 8'h60 && (reg_addr[7:4] > 4'h4 || reg_addr[3:0] > 4'h5)))
		|=> reg_rdata == 16'h0) else $error("unmapped read not zero");
	a_glb_read: assert property (reg_rd && reg_addr == 8'h62 |=> reg_rdata ==
		{9'h0, $past(event_out), $past(alarm_present), $past(ready_mode)})
		else $error("global status wrong");
	a_evstat_read: assert property (reg_rd && reg_addr == 8'h05 |=>
		reg_rdata[3] == $past(event_raw[0]) && reg_rdata[0] == $past(event_out[0]))
		else $error("event status wrong");
	a_irq_rise: assert property ((event_out & ~$past(event_out) & msk_reg) != 5'h0
		|-> ##[1:2] irq) else $error("irq missing");
	a_irq_mask: assert property (irq |-> ($past(msk_reg) | $past(msk_reg, 2)) != 5'h0)
		else $error("irq while masked");
	a_reset_quiet: assert property (disable iff (1'b0) !rst_b |=>
		event_out == 5'h0 && !irq && reg_rdata == 16'h0) else $error("reset outputs");

	c_irq: cover property (irq);
	c_rdy_fall: cover property ($fell(ready_mode) && event_raw != 5'h0);
	c_ev_rise: cover property ($rose(event_out[0]));
endmodule

bind ieq_top ieq_chk #(.TICK_CYC(TICK_CYC)) u_chk (
	.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .event_raw(event_raw),
	.alarm_present(alarm_present), .ready_mode(ready_mode), .sp_value(sp_value),
	.event_out(event_out), .irq(irq));

// ===== testbench/ieq_src.sv
// Partner model: event comparators, alarm summary and mode
`timescale 1ns/1ps
module ieq_src (
	// Clock and control
	input wire        sys_clk,
	input wire        go,
	// Sources
	output reg [4:0]  event_raw,
	output reg        alarm_present,
	output reg        ready_mode,
	output reg [15:0] sp_value
);
	initial begin
		event_raw = 5'h00;
		alarm_present = 1'b0;
		ready_mode = 1'b1;
		sp_value = 16'h0000;
	end
	// Idle holds READY with all conditions quiet
	always @(posedge sys_clk) begin
		if (!go) begin
			event_raw <= 5'h00;
			alarm_present <= 1'b0;
			ready_mode <= 1'b1;
		end else begin
			if ($urandom % 4 == 0)
				event_raw <= 5'($urandom);
			if ($urandom % 8 == 0)
				alarm_present <= ~alarm_present;
			if ($urandom % 40 == 0)
				ready_mode <= ~ready_mode;
			// Half of the setpoint writes repeat the value
			if ($urandom % 16 == 0)
				sp_value <= sp_value + 16'($urandom % 2);
		end
	end
endmodule

// ===== testbench/test_internal_event_qualifier.sv
// Self-checking bench of the five event qualifiers
`timescale 1ns/1ps
module test_internal_event_qualifier;
	reg         sys_clk, rst_b, reg_wr, reg_rd, go, chk_on, rdy_q, v, arm;
	reg  [7:0]  reg_addr;
	reg  [15:0] reg_wdata, sp_q, m;
	reg  [15:0] cfg2 [0:4];
	reg  [15:0] cfg3 [0:4];
	reg  [15:0] mainv [0:4];
	reg  [4:0]  stby, pre, ok;
	reg  [3:0]  sd;
	wire [15:0] reg_rdata, sp_value;
	wire [4:0]  event_raw, event_out;
	wire        alarm_present, ready_mode, irq;
	integer     mismatches, checks, cyc, i, k, n, p, u, t;

	ieq_top #(.TICK_CYC(4)) DUT (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.event_raw(event_raw), .alarm_present(alarm_present), .ready_mode(ready_mode),
		.sp_value(sp_value), .event_out(event_out), .irq(irq));
	ieq_src u_src (.sys_clk(sys_clk), .go(go), .event_raw(event_raw),
		.alarm_present(alarm_present), .ready_mode(ready_mode), .sp_value(sp_value));

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	task check(input [15:0] got, input [15:0] exp);
		begin
			checks = checks + 1;
			if (got !== exp) begin
				mismatches = mismatches + 1;
				$display("[FAIL] %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task wr(input [7:0] a, input [15:0] d);
		begin
			@(posedge sys_clk);
			reg_wr <= 1'b1;
			reg_addr <= a;
			reg_wdata <= d;
			@(posedge sys_clk);
			reg_wr <= 1'b0;
		end
	endtask
	task rd(input [7:0] a, input [15:0] e);
		begin
			@(posedge sys_clk);
			reg_rd <= 1'b1;
			reg_addr <= a;
			@(posedge sys_clk);
			reg_rd <= 1'b0;
			@(negedge sys_clk);
			check(reg_rdata, e);
		end
	endtask
	task wrap_up;
		begin
			if (mismatches == 0 && checks > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask

	// Cycle ceiling
	always @(posedge sys_clk) begin
		cyc = cyc + 1;
		if (cyc == 9000) begin
			mismatches = mismatches + 1;
			wrap_up;
		end
	end

	// Reference model of the pre-delay level, delays zero
	always @(negedge sys_clk) begin
		if (!rst_b) begin
			stby = 5'h1f;
			ok = 5'h00;
			rdy_q = ready_mode;
			sp_q = sp_value;
		end else begin
			if (chk_on)
				check({11'h0, event_out & ok}, {11'h0, pre & ok});
			for (k = 0; k < 5; k = k + 1) begin
				sd = cfg2[k][7:4];
				arm = (rdy_q & ~ready_mode) | (sd == 4'h2 && sp_value != sp_q);
				v = event_raw[k] ^ (cfg2[k][3:0] == 4'h1);
				if (((sd == 4'h1 || sd == 4'h2) && (stby[k] || ready_mode))
					|| (cfg2[k][11:8] == 4'h1 && ready_mode))
					v = 1'b0;
				case (cfg3[k][3:0])
					4'h1: v = v | alarm_present;
					4'h2: v = v & alarm_present;
					4'h3: v = v | !alarm_present;
					4'h4: v = v & !alarm_present;
					default: v = v;
				endcase
				if (cfg3[k][7:4] == 4'h1 && mainv[k] == 16'h0)
					v = 1'b0;
				pre[k] = v;
				ok[k] = !arm;
				// Standby disabled clears the armed state at once
				stby[k] = (sd == 4'h1 || sd == 4'h2) ? (arm | (stby[k] & event_raw[k])) : 1'b0;
			end
			rdy_q = ready_mode;
			sp_q = sp_value;
		end
	end

	initial begin
		rst_b = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		go = 1'b0;
		chk_on = 1'b0;
		mismatches = 0;
		checks = 0;
		cyc = 0;
		for (i = 0; i < 5; i = i + 1) begin
			cfg2[i] = 16'h0;
			cfg3[i] = 16'h0;
			mainv[i] = 16'h0;
		end
		n = $urandom(46629);
		repeat (20) @(posedge sys_clk);
		rst_b <= 1'b1;
		for (i = 0; i < 8'h63; i = i + 1)
			if (i[3:0] < 6 || i > 8'h5f)
				rd(8'(i), (i == 8'h62) ? 16'h0001 : 16'h0);
		rd(8'h70, 16'h0);
		wr(8'h40, 16'hf121);
		rd(8'h40, 16'h0121);
		wr(8'h14, 16'hffff);
		rd(8'h14, 16'h270f);
		wr(8'h14, 16'h0);
		for (p = 0; p < 6; p = p + 1) begin
			chk_on = 1'b0;
			go <= 1'b0;
			for (i = 0; i < 5; i = i + 1) begin
				cfg2[i] = {4'($urandom), 4'(p % 2), 4'((p + i) % 3), 4'((p + i) % 2)};
				cfg3[i] = {4'($urandom), 4'($urandom % 2), 4'($urandom % 2), 4'((p + i) % 5)};
				m = ($urandom % 2) ? 16'h0 : 16'($urandom);
				mainv[i] = m;
				wr(8'(16 * i), cfg2[i]);
				wr(8'(16 * i + 1), cfg3[i]);
				wr(8'(16 * i + 2), m);
			end
			repeat (3) @(posedge sys_clk);
			chk_on = 1'b1;
			go <= 1'b1;
			repeat (250) @(posedge sys_clk);
		end
		chk_on = 1'b0;
		go <= 1'b0;
		for (i = 0; i < 5; i = i + 1) begin
			wr(8'(16 * i), 16'h0);
			wr(8'(16 * i + 1), 16'h0);
		end
		wr(8'h61, 16'h0001);
		wr(8'h60, 16'h001f);
		rd(8'h60, 16'h0);
		wr(8'h01, 16'h0003);
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk);
		check({15'h0, irq}, 16'h1);
		rd(8'h60, 16'h0001);
		wr(8'h61, 16'h0);
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		check({15'h0, irq}, 16'h0);
		wr(8'h60, 16'h0001);
		rd(8'h60, 16'h0);
		wr(8'h03, 16'h0001);
		for (u = 0; u < 3; u = u + 1) begin
			wr(8'h01, 16'(u << 8));
			wr(8'h00, 16'h0);
			repeat (3) @(posedge sys_clk);
			wr(8'h00, 16'h0001);
			n = 0;
			t = (u == 0) ? 4 : (u == 1) ? 40 : 2400;
			while (event_out[0] !== 1'b1 && n < 3000) begin
				@(negedge sys_clk);
				n = n + 1;
			end
			check(16'(n >= t - 4 && n <= t + 3), 16'h1);
		end
		wrap_up;
	end
endmodule
